// file: smr_pkg.sv
// constants, state type and per-mode enable masks for the sleep and reset controller
// assumes one 100 MHz clock; no software-visible bus, control arrives on plain ports

package smr_pkg;

  // ****************************************************************
  // clock and external reset timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS    = 10;
  // minimum low time of the external reset pin; plain default, no figure printed
  localparam int RST_MIN_PULSE_NS = 2500;
  // least time, so round up to whole cycles
  localparam int RST_MIN_CYC      = (RST_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // sleep mode codes (six valid, two left unused)
  // ****************************************************************
  localparam int         MODE_W      = 3;
  localparam logic [2:0] MODE_IDLE   = 3'h0;
  localparam logic [2:0] MODE_ADCNR  = 3'h1;
  localparam logic [2:0] MODE_PDOWN  = 3'h2;
  localparam logic [2:0] MODE_PSAVE  = 3'h3;
  localparam logic [2:0] MODE_STBY   = 3'h4;
  localparam logic [2:0] MODE_XSTBY  = 3'h5;
  localparam logic [2:0] MODE_RESET  = MODE_IDLE;
  localparam logic       SE_RESET    = 1'b0;

  // ****************************************************************
  // unit enable vector: bit positions and per-mode masks
  // ****************************************************************
  localparam int UNIT_W   = 7;
  localparam int UB_CPU   = 0;
  localparam int UB_OSC   = 1;
  localparam int UB_ATMR  = 2;
  localparam int UB_ADC   = 3;
  localparam int UB_IO    = 4;
  localparam int UB_IRQ   = 5;
  localparam int UB_SRAM  = 6;

  localparam logic [6:0] EN_ACTIVE = 7'h7f;
  localparam logic [6:0] EN_IDLE   = 7'h7e;
  localparam logic [6:0] EN_ADCNR  = 7'h0e;
  localparam logic [6:0] EN_PDOWN  = 7'h00;
  localparam logic [6:0] EN_PSAVE  = 7'h04;
  localparam logic [6:0] EN_STBY   = 7'h02;
  localparam logic [6:0] EN_XSTBY  = 7'h06;

  typedef enum logic {ST_ACTIVE, ST_SLEEP} smr_state_t;

  function automatic logic smr_mode_ok(input logic [2:0] m);
    smr_mode_ok = (m <= MODE_XSTBY);
  endfunction : smr_mode_ok

endpackage : smr_pkg

// file: smr_rst_filter.sv
// minimum-pulse filter for the external active-low reset pin
// assumes the pin is already synchronous to the clock

`timescale 1ns/1ps
`default_nettype none

module smr_rst_filter
  import smr_pkg::*;
#(
  parameter int MIN_CYC = RST_MIN_CYC
) (
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  input  wire logic i_pin_rst_n,
  output logic      o_rst_req
);

  localparam int CW = $clog2(MIN_CYC + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(MIN_CYC);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          rst_req_reg;

  // ****************************************************************
  // low-time counter
  // ****************************************************************
  // a short glitch restarts the count, so only a full-length pulse resets
  always_comb begin
    if (i_pin_rst_n) begin
      cnt_next = '0;
    end else if (cnt_reg == CNT_MAX) begin
      cnt_next = cnt_reg;
    end else begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      cnt_reg     <= '0;
      rst_req_reg <= 1'b0;
    end else if (i_ce) begin
      cnt_reg     <= cnt_next;                 // see RULE_09
      rst_req_reg <= (cnt_next == CNT_MAX);    // see RULE_09
    end
  end

  assign o_rst_req = rst_req_reg;

  rst_long_low_a : assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // see RULE_09
    o_rst_req |-> (cnt_reg == CNT_MAX))
    else $error("reset request without a full-length low pulse");

  rst_pin_high_a : assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // see RULE_09
    (i_ce && i_pin_rst_n) |=> !o_rst_req)
    else $error("reset request held after the pin went high");

endmodule : smr_rst_filter

`default_nettype wire

// file: smr_sleep_ctrl.sv
// sleep mode and reset controller: mode/enable holding, sleep state machine,
// per-unit clock enables and reset-driven port tri-state
// assumes a 100 MHz clock, synchronous inputs and a wake source that works in every mode
//
// How it works
// RULE_01 - software can choose any of six sleep modes before sleeping.
// RULE_02 - idle stops only the cpu clock; sram, timers, spi and interrupts run on.
// RULE_03 - power-down stops the oscillator and every unit, keeping state until a wake or reset.
// RULE_04 - power-save is power-down with the asynchronous timer still running.
// RULE_05 - converter noise reduction keeps only the asynchronous timer and the converter running; the code also keeps the main oscillator on (EN_ADCNR).
// RULE_06 - standby keeps the main oscillator running while everything else sleeps.
// RULE_07 - extended standby keeps the main oscillator and asynchronous timer running.
// RULE_08 - any active reset tri-states every port pin at once, without needing the clock.
// RULE_09 - a low on the reset pin longer than the minimum pulse resets the device.
// RULE_10 - a sleep request with the enable set enters the held mode; a wake returns to active.

`timescale 1ns/1ps
`default_nettype none

module smr_sleep_ctrl
  import smr_pkg::*;
#(
  parameter int PORT_W  = 32,
  parameter int MIN_CYC = RST_MIN_CYC
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_ce,
  input  wire logic              i_ext_rst_n,
  input  wire logic              i_ctl_wr,
  input  wire logic [MODE_W-1:0] i_ctl_mode,
  input  wire logic              i_ctl_se,
  input  wire logic              i_sleep_req,
  input  wire logic              i_wake,
  input  wire logic [PORT_W-1:0] i_port_oe,
  output logic      [MODE_W-1:0] o_ctl_mode,
  output logic                   o_ctl_se,
  output logic                   o_sleeping,
  output logic                   o_rst_active,
  output logic                   o_cpu_clk_en,
  output logic                   o_osc_en,
  output logic                   o_atmr_en,
  output logic                   o_adc_clk_en,
  output logic                   o_io_clk_en,
  output logic                   o_irq_clk_en,
  output logic                   o_sram_clk_en,
  output logic      [PORT_W-1:0] o_port_oe
);

  logic [MODE_W-1:0] mode_reg;
  logic [MODE_W-1:0] mode_next;
  logic              se_reg;
  logic              se_next;
  smr_state_t        state_reg;
  smr_state_t        state_next;
  logic [UNIT_W-1:0] unit_en_reg;
  logic [UNIT_W-1:0] unit_en_next;
  logic              ext_rst_req;
  logic              rst_int;
  logic              rst_async;

  // ****************************************************************
  // external reset filter
  // ****************************************************************
  smr_rst_filter #(
    .MIN_CYC     (MIN_CYC)
  ) u_rst_filter (
    .i_ref_clk   (i_ref_clk),
    .i_resetn    (i_resetn),
    .i_ce        (i_ce),
    .i_pin_rst_n (i_ext_rst_n),
    .o_rst_req   (ext_rst_req)
  );

  // a filtered pin reset acts exactly like the system reset on all state here
  assign rst_int = !i_resetn || ext_rst_req;  // see RULE_09

  // ****************************************************************
  // port tri-state on reset
  // ****************************************************************
  // purely combinational so the pins float even with the clock stopped;
  // the raw pin is used here, so even a short low floats the pins while it lasts
  assign rst_async    = !i_ext_rst_n || !i_resetn || ext_rst_req;
  assign o_rst_active = rst_async;

  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_port
      assign o_port_oe[gi] = i_port_oe[gi] && !rst_async;  // see RULE_08
    end
  endgenerate

  // ****************************************************************
  // mode and enable holding
  // ****************************************************************
  // an unused mode code leaves the held mode alone; the enable still updates
  always_comb begin
    mode_next = mode_reg;
    se_next   = se_reg;
    if (i_ctl_wr) begin
      se_next = i_ctl_se;
      if (smr_mode_ok(i_ctl_mode)) begin
        mode_next = i_ctl_mode;  // see RULE_01
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (rst_int) begin
      mode_reg <= MODE_RESET;
      se_reg   <= SE_RESET;
    end else if (i_ce) begin
      mode_reg <= mode_next;  // see RULE_10
      se_reg   <= se_next;    // see RULE_10
    end
  end

  // ****************************************************************
  // sleep state machine
  // ****************************************************************
  // a wake that meets the request in the same cycle wins, so no wake is lost
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_ACTIVE: begin
        if (i_sleep_req && se_reg && !i_wake) begin
          state_next = ST_SLEEP;  // see RULE_10
        end
      end
      ST_SLEEP: begin
        if (i_wake) begin
          state_next = ST_ACTIVE;  // see RULE_10
        end
      end
      default: begin
        state_next = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (rst_int) begin
      state_reg <= ST_ACTIVE;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // per-unit enables
  // ****************************************************************
  // computed from the next state so the enables change on the same edge as the state
  always_comb begin
    unit_en_next = EN_ACTIVE;
    if (state_next == ST_SLEEP) begin
      case (mode_next)
        MODE_IDLE:  unit_en_next = EN_IDLE;   // see RULE_02
        MODE_ADCNR: unit_en_next = EN_ADCNR;  // see RULE_05
        MODE_PDOWN: unit_en_next = EN_PDOWN;  // see RULE_03
        MODE_PSAVE: unit_en_next = EN_PSAVE;  // see RULE_04
        MODE_STBY:  unit_en_next = EN_STBY;   // see RULE_06
        MODE_XSTBY: unit_en_next = EN_XSTBY;  // see RULE_07
        default:    unit_en_next = EN_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (rst_int) begin
      unit_en_reg <= EN_ACTIVE;
    end else if (i_ce) begin
      unit_en_reg <= unit_en_next;
    end
  end

  assign o_ctl_mode    = mode_reg;
  assign o_ctl_se      = se_reg;
  assign o_sleeping    = (state_reg == ST_SLEEP);
  assign o_cpu_clk_en  = unit_en_reg[UB_CPU];
  assign o_osc_en      = unit_en_reg[UB_OSC];
  assign o_atmr_en     = unit_en_reg[UB_ATMR];
  assign o_adc_clk_en  = unit_en_reg[UB_ADC];
  assign o_io_clk_en   = unit_en_reg[UB_IO];
  assign o_irq_clk_en  = unit_en_reg[UB_IRQ];
  assign o_sram_clk_en = unit_en_reg[UB_SRAM];

  // ****************************************************************
  // checks
  // ****************************************************************
  mode_valid_a : assert property (@(posedge i_ref_clk) disable iff (rst_int) // see RULE_01
    (i_ce && i_ctl_wr && !smr_mode_ok(i_ctl_mode)) |=> $stable(mode_reg))
    else $error("unused mode code was accepted");

  idle_units_a : assert property (@(posedge i_ref_clk) disable iff (rst_int) // see RULE_02
    (o_sleeping && mode_reg == MODE_IDLE) |->
      (!o_cpu_clk_en && o_sram_clk_en && o_io_clk_en && o_irq_clk_en))
    else $error("idle mode gating wrong");

  pdown_units_a : assert property (@(posedge i_ref_clk) disable iff (rst_int) // see RULE_03
    (o_sleeping && mode_reg == MODE_PDOWN) |-> (unit_en_reg == '0))
    else $error("power-down left a unit running");

  psave_units_a : assert property (@(posedge i_ref_clk) disable iff (rst_int) // see RULE_04
    (o_sleeping && mode_reg == MODE_PSAVE) |-> (o_atmr_en && !o_osc_en && !o_cpu_clk_en))
    else $error("power-save gating wrong");

  adcnr_units_a : assert property (@(posedge i_ref_clk) disable iff (rst_int) // see RULE_05
    (o_sleeping && mode_reg == MODE_ADCNR) |->
      (o_atmr_en && o_adc_clk_en && !o_cpu_clk_en && !o_io_clk_en))
    else $error("noise-reduction gating wrong");

  stby_units_a : assert property (@(posedge i_ref_clk) disable iff (rst_int) // see RULE_06
    (o_sleeping && mode_reg == MODE_STBY) |-> (o_osc_en && !o_atmr_en && !o_cpu_clk_en))
    else $error("standby gating wrong");

  xstby_units_a : assert property (@(posedge i_ref_clk) disable iff (rst_int) // see RULE_07
    (o_sleeping && mode_reg == MODE_XSTBY) |-> (o_osc_en && o_atmr_en && !o_io_clk_en))
    else $error("extended standby gating wrong");

  port_float_a : assert property (@(posedge i_ref_clk) // see RULE_08
    !i_ext_rst_n |-> (o_port_oe == '0))
    else $error("port driven during reset");

  sleep_entry_a : assert property (@(posedge i_ref_clk) disable iff (rst_int) // see RULE_10
    (i_ce && !o_sleeping && i_sleep_req && se_reg && !i_wake) |=> (o_sleeping && !o_cpu_clk_en))
    else $error("sleep request not taken");

  wake_exit_a : assert property (@(posedge i_ref_clk) disable iff (rst_int) // see RULE_10
    (i_ce && o_sleeping && i_wake) |=> (!o_sleeping && unit_en_reg == EN_ACTIVE))
    else $error("wake did not restore active operation");

  no_enable_a : assert property (@(posedge i_ref_clk) disable iff (rst_int) // see RULE_10
    (i_ce && !o_sleeping && !se_reg) |=> !o_sleeping)
    else $error("slept with the enable clear");

endmodule : smr_sleep_ctrl

`default_nettype wire

// file: smr_sleep_ctrl_tb.sv
// self-checking bench for the sleep mode and reset controller
// assumes smr_pkg is compiled first; drives every port itself, no partner model

`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, act) begin \
  samples_checked++; \
  if ((act) !== (exp)) begin \
    n_fail++; \
    $display("mismatch %s expected %h seen %h", nm, exp, act); \
  end \
end

module smr_sleep_ctrl_tb
  import smr_pkg::*;
;
  // ****************************************************************
  // signals and instance
  // ****************************************************************
  localparam int PW = 8;
  // short pulse filter keeps the run brief
  localparam int MC = 4;

  logic              i_ref_clk;
  logic              i_resetn;
  logic              i_ce;
  logic              i_ext_rst_n;
  logic              i_ctl_wr;
  logic [MODE_W-1:0] i_ctl_mode;
  logic              i_ctl_se;
  logic              i_sleep_req;
  logic              i_wake;
  logic [PW-1:0]     i_port_oe;
  logic [MODE_W-1:0] o_ctl_mode;
  logic              o_ctl_se;
  logic              o_sleeping;
  logic              o_rst_active;
  // each bit is driven by its own output port, so this is a net
  wire logic [6:0]   en_vec;
  logic [PW-1:0]     o_port_oe;
  int                n_fail;
  int                samples_checked;

  smr_sleep_ctrl #(.PORT_W(PW), .MIN_CYC(MC)) i_smr_sleep_ctrl (
    .i_ref_clk     (i_ref_clk),
    .i_resetn      (i_resetn),
    .i_ce          (i_ce),
    .i_ext_rst_n   (i_ext_rst_n),
    .i_ctl_wr      (i_ctl_wr),
    .i_ctl_mode    (i_ctl_mode),
    .i_ctl_se      (i_ctl_se),
    .i_sleep_req   (i_sleep_req),
    .i_wake        (i_wake),
    .i_port_oe     (i_port_oe),
    .o_ctl_mode    (o_ctl_mode),
    .o_ctl_se      (o_ctl_se),
    .o_sleeping    (o_sleeping),
    .o_rst_active  (o_rst_active),
    .o_cpu_clk_en  (en_vec[UB_CPU]),
    .o_osc_en      (en_vec[UB_OSC]),
    .o_atmr_en     (en_vec[UB_ATMR]),
    .o_adc_clk_en  (en_vec[UB_ADC]),
    .o_io_clk_en   (en_vec[UB_IO]),
    .o_irq_clk_en  (en_vec[UB_IRQ]),
    .o_sram_clk_en (en_vec[UB_SRAM]),
    .o_port_oe     (o_port_oe)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  function automatic logic [6:0] mask_of(input logic [2:0] m);
    case (m)
      MODE_IDLE:  mask_of = EN_IDLE;
      MODE_ADCNR: mask_of = EN_ADCNR;
      MODE_PDOWN: mask_of = EN_PDOWN;
      MODE_PSAVE: mask_of = EN_PSAVE;
      MODE_STBY:  mask_of = EN_STBY;
      default:    mask_of = EN_XSTBY;
    endcase
  endfunction : mask_of

  // expected values are passed in, since a frozen clock enable keeps the old ones
  task automatic do_write(input logic [2:0] m, input logic s, input logic [2:0] exp_m,
                          input logic exp_s);
    @(posedge i_ref_clk);
    i_ctl_wr   <= 1'b1;
    i_ctl_mode <= m;
    i_ctl_se   <= s;
    @(posedge i_ref_clk);
    i_ctl_wr   <= 1'b0;
    #1;
    `CHK("ctl_mode", exp_m, o_ctl_mode)
    `CHK("ctl_se", exp_s, o_ctl_se)
  endtask : do_write

  // request lands one edge later; wake in the same cycle when w is set
  task automatic do_sleep(input logic w);
    @(posedge i_ref_clk);
    i_sleep_req <= 1'b1;
    i_wake      <= w;
    @(posedge i_ref_clk);
    i_sleep_req <= 1'b0;
    i_wake      <= 1'b0;
    #1;
  endtask : do_sleep

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // reset is low from time zero, so it is sampled low on exactly four edges
  task automatic t_reset();
    repeat (3) @(posedge i_ref_clk);
    #1;
    `CHK("oe_in_reset", {PW{1'b0}}, o_port_oe)
    `CHK("rst_active", 1'b1, o_rst_active)
    `CHK("mode_rst", MODE_RESET, o_ctl_mode)
    `CHK("en_rst", EN_ACTIVE, en_vec)
    @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    #1;
    `CHK("oe_free", {PW{1'b1}}, o_port_oe)
    // a mixed pattern shows each enable is passed through, not stuck high
    @(posedge i_ref_clk);
    i_port_oe <= 8'h5a;
    #1;
    `CHK("oe_pass", 8'h5a, o_port_oe)
    @(posedge i_ref_clk);
    i_port_oe <= {PW{1'b1}};
  endtask : t_reset

  task automatic t_modes();
    for (int m = 0; m < 6; m++) begin
      do_write(3'(m), 1'b1, 3'(m), 1'b1);
      do_sleep(1'b0);
      `CHK("asleep", 1'b1, o_sleeping)
      `CHK("mode_mask", mask_of(3'(m)), en_vec)
      @(posedge i_ref_clk);
      i_wake <= 1'b1;
      @(posedge i_ref_clk);
      i_wake <= 1'b0;
      #1;
      `CHK("awake", 1'b0, o_sleeping)
      `CHK("en_awake", EN_ACTIVE, en_vec)
    end
  endtask : t_modes

  task automatic t_refuse();
    do_write(MODE_PSAVE, 1'b0, MODE_PSAVE, 1'b0);
    do_sleep(1'b0);
    `CHK("no_se_sleep", 1'b0, o_sleeping)
    do_write(3'h6, 1'b1, MODE_PSAVE, 1'b1);
    do_write(3'h7, 1'b1, MODE_PSAVE, 1'b1);
    do_sleep(1'b1);
    `CHK("wake_wins", 1'b0, o_sleeping)
    // a frozen clock enable must not let a write through
    @(posedge i_ref_clk);
    i_ce <= 1'b0;
    do_write(MODE_XSTBY, 1'b0, MODE_PSAVE, 1'b1);
    @(posedge i_ref_clk);
    i_ce <= 1'b1;
  endtask : t_refuse

  task automatic t_pin();
    do_write(MODE_PDOWN, 1'b1, MODE_PDOWN, 1'b1);
    do_sleep(1'b0);
    @(posedge i_ref_clk);
    i_ext_rst_n <= 1'b0;
    #1;
    `CHK("oe_pin_low", {PW{1'b0}}, o_port_oe)
    // one low sample short of the filter length: must not reset
    repeat (MC - 1) @(posedge i_ref_clk);
    i_ext_rst_n <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1;
    `CHK("short_kept", 1'b1, o_sleeping)
    `CHK("short_mode", MODE_PDOWN, o_ctl_mode)
    // the filter asserts on the MC-th low sample and the state clears one edge later
    @(posedge i_ref_clk);
    i_ext_rst_n <= 1'b0;
    repeat (MC + 1) @(posedge i_ref_clk);
    #1;
    `CHK("long_sleep", 1'b0, o_sleeping)
    `CHK("long_mode", MODE_RESET, o_ctl_mode)
    `CHK("long_en", EN_ACTIVE, en_vec)
    @(posedge i_ref_clk);
    i_ext_rst_n <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1;
    `CHK("rst_gone", 1'b0, o_rst_active)
    `CHK("oe_back", {PW{1'b1}}, o_port_oe)
  endtask : t_pin

  // ****************************************************************
  // clock, watchdog, main sequence
  // ****************************************************************
  task automatic tally_and_finish();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // whole sequence needs well under 300 cycles
  initial begin
    repeat (3000) @(posedge i_ref_clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    n_fail          = 0;
    samples_checked = 0;
    i_resetn        = 1'b0;
    i_ce            = 1'b1;
    i_ext_rst_n     = 1'b1;
    i_ctl_wr        = 1'b0;
    i_ctl_mode      = 3'h0;
    i_ctl_se        = 1'b0;
    i_sleep_req     = 1'b0;
    i_wake          = 1'b0;
    i_port_oe       = {PW{1'b1}};
    t_reset();
    t_modes();
    t_refuse();
    t_pin();
    tally_and_finish();
  end

endmodule : smr_sleep_ctrl_tb

`default_nettype wire
